// File: hdl/pcit_pkg.sv
// Shared constants and types for the instruction timing sequencer.
// Assumes a single system clock and a code store read in the same cycle.
package pcit_pkg;

  // ==========================================================================
  // Clocking and timing limits
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CORE_MAX_HZ = 25_000_000; // Rated system clock ceiling
  localparam logic [3:0] MAX_CLOCKS = 4'h8;         // No instruction runs longer
  localparam logic [3:0] MUL_CLOCKS = 4'h4;
  localparam logic [3:0] DIV_CLOCKS = 4'h8;
  localparam int unsigned INSTR_COUNT = 109;        // Distinct instructions decoded

  // ==========================================================================
  // Reset values and the spare opcode
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] NOP_OPCODE = 8'h00;
  localparam logic [7:0] SPARE_OPCODE = 8'ha5;      // Runs as a no-operation

  // ==========================================================================
  // Execution classes steering the datapath and memory strobes
  typedef enum logic [3:0] {
    CLS_PLAIN  = 4'h0,
    CLS_COND   = 4'h1,
    CLS_JUMP   = 4'h2,
    CLS_MUL    = 4'h3,
    CLS_DIV    = 4'h4,
    CLS_XRD    = 4'h5,
    CLS_XWR    = 4'h6,
    CLS_CODERD = 4'h7
  } pcit_cls_e;

  // Per-opcode timing record
  typedef struct packed {
    logic [1:0] len;   // Program bytes
    logic [3:0] clk;   // Clocks, not-taken count for conditional branches
    pcit_cls_e cls;
  } pcit_dec_s;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_FETCH   = 3'b001,
    ST_EXEC    = 3'b010,
    ST_DISCARD = 3'b100
  } pcit_state_e;

endpackage

// File: hdl/pcit_exec_ctrl.sv
// Execution control of a pipelined eight-bit controller core: opcode timing
// decode, operand byte capture, program counter sequencing and memory strobes.
// Assumes the code store returns CODE_DATA for CODE_ADDR within the same cycle
// and that the datapath supplies branch condition and target on this clock.
module pcit_exec_ctrl (
  input wire logic CLK,                     // System clock
  input wire logic RST,                     // Asynchronous reset, active high
  output logic [15:0] CODE_ADDR,            // Program fetch address
  input wire logic [7:0] CODE_DATA,         // Program byte at CODE_ADDR
  input wire logic BR_COND,                 // Branch condition from datapath
  input wire logic [15:0] BR_TARGET,        // Jump or branch destination
  input wire logic PROG_STORE_WE,           // Program store write enable bit
  output logic [7:0] OPCODE,                // Opcode of current instruction
  output logic [7:0] OPERAND1,              // Second program byte
  output logic [7:0] OPERAND2,              // Third program byte
  output pcit_pkg::pcit_cls_e EXEC_CLASS,   // Class of current instruction
  output logic [3:0] EXEC_CYCLE,            // Clock index within instruction
  output logic EXEC_LAST,                   // Final execute clock of a multi-clock instruction
  output logic MULDIV_STEP,                 // Iteration enable for multiply/divide
  output logic ONCHIP_EXTERNAL_RAM_SPACE_RD,                     // On-chip external RAM read strobe
  output logic ONCHIP_EXTERNAL_RAM_SPACE_WR,                     // On-chip external RAM write strobe
  output logic FLASH_WR,                    // Program flash byte write strobe
  output logic FLASH_RD,                    // Program flash data byte read strobe
  output logic INSTR_DONE                   // Pulse after each instruction retires
);

  // ==========================================================================
  // Opcode timing table
  // Grouped by low nibble as the opcode map is laid out; unlisted codes fall
  // to their nibble's default record; the spare opcode has its own explicit row.
  function automatic pcit_pkg::pcit_dec_s decode(input logic [7:0] op);
    pcit_pkg::pcit_dec_s d;
    d = '{len: 2'h1, clk: 4'h1, cls: pcit_pkg::CLS_PLAIN};
    case (op[3:0])
      // Low nibble 0: no-operation, bit-test branches, carry and zero branches,
      // short jump, data pointer load, boolean carry ops, stack push and pop,
      // and the data-pointer external moves. Conditional rows carry the
      // not-taken count; the sequencer adds the discard clock when taken.
      4'h0: begin
        case (op[7:4])
          4'h0: d = '{len: 2'h1, clk: 4'h1, cls: pcit_pkg::CLS_PLAIN};
          4'h1, 4'h2, 4'h3: d = '{len: 2'h3, clk: 4'h3, cls: pcit_pkg::CLS_COND};
          4'h4, 4'h5, 4'h6, 4'h7: d = '{len: 2'h2, clk: 4'h2, cls: pcit_pkg::CLS_COND};
          4'h8: d = '{len: 2'h2, clk: 4'h3, cls: pcit_pkg::CLS_JUMP};
          4'h9: d = '{len: 2'h3, clk: 4'h3, cls: pcit_pkg::CLS_PLAIN};
          4'he: d = '{len: 2'h1, clk: 4'h3, cls: pcit_pkg::CLS_XRD};
          4'hf: d = '{len: 2'h1, clk: 4'h3, cls: pcit_pkg::CLS_XWR};
          default: d = '{len: 2'h2, clk: 4'h2, cls: pcit_pkg::CLS_PLAIN};
        endcase
      end
      // Low nibble 1: every row is an absolute jump or call within the page,
      // so the whole column shares one record
      4'h1: d = '{len: 2'h2, clk: 4'h3, cls: pcit_pkg::CLS_JUMP};
      // Low nibble 2: long jump and call, the two returns, the register
      // indirect external moves, and the accumulator-into-direct logic and
      // bit operations that all run two bytes in two clocks.
      // Returns are one byte but spend five clocks reloading the counter.
      4'h2: begin
        case (op[7:4])
          4'h0, 4'h1: d = '{len: 2'h3, clk: 4'h4, cls: pcit_pkg::CLS_JUMP};
          4'h2, 4'h3: d = '{len: 2'h1, clk: 4'h5, cls: pcit_pkg::CLS_JUMP};
          4'he: d = '{len: 2'h1, clk: 4'h3, cls: pcit_pkg::CLS_XRD};
          4'hf: d = '{len: 2'h1, clk: 4'h3, cls: pcit_pkg::CLS_XWR};
          default: d = '{len: 2'h2, clk: 4'h2, cls: pcit_pkg::CLS_PLAIN};
        endcase
      end
      // Low nibble 3: immediate-into-direct logic, indirect jump, both code
      // byte moves, the remaining external moves, and one-clock rotates,
      // carry ops and the data pointer increment.
      // Code byte moves raise the flash read strobe in their last clock.
      4'h3: begin
        case (op[7:4])
          4'h4, 4'h5, 4'h6: d = '{len: 2'h3, clk: 4'h3, cls: pcit_pkg::CLS_PLAIN};
          4'h7: d = '{len: 2'h1, clk: 4'h3, cls: pcit_pkg::CLS_JUMP};
          4'h8, 4'h9: d = '{len: 2'h1, clk: 4'h3, cls: pcit_pkg::CLS_CODERD};
          4'he: d = '{len: 2'h1, clk: 4'h3, cls: pcit_pkg::CLS_XRD};
          4'hf: d = '{len: 2'h1, clk: 4'h3, cls: pcit_pkg::CLS_XWR};
          default: d = '{len: 2'h1, clk: 4'h1, cls: pcit_pkg::CLS_PLAIN};
        endcase
      end
      // Low nibble 4: immediate-to-accumulator arithmetic and logic, the
      // multiply and divide iterations, compare-immediate branch, and the
      // one-clock accumulator ops such as increment, swap and clear.
      // Divide is the longest record; nothing may exceed it.
      4'h4: begin
        case (op[7:4])
          4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: d = '{len: 2'h2, clk: 4'h2, cls: pcit_pkg::CLS_PLAIN};
          4'h8: d = '{len: 2'h1, clk: pcit_pkg::DIV_CLOCKS, cls: pcit_pkg::CLS_DIV};
          4'ha: d = '{len: 2'h1, clk: pcit_pkg::MUL_CLOCKS, cls: pcit_pkg::CLS_MUL};
          4'hb: d = '{len: 2'h3, clk: 4'h3, cls: pcit_pkg::CLS_COND};
          default: d = '{len: 2'h1, clk: 4'h1, cls: pcit_pkg::CLS_PLAIN};
        endcase
      end
      // Low nibble 5: direct-byte forms, the three-byte moves, the spare
      // code that must time exactly as a no-operation, compare-direct and
      // decrement-direct branches.
      // Keeping the spare code here makes its one-clock record explicit.
      4'h5: begin
        case (op[7:4])
          4'h7, 4'h8: d = '{len: 2'h3, clk: 4'h3, cls: pcit_pkg::CLS_PLAIN};
          4'ha: d = '{len: 2'h1, clk: 4'h1, cls: pcit_pkg::CLS_PLAIN};
          4'hb, 4'hd: d = '{len: 2'h3, clk: 4'h3, cls: pcit_pkg::CLS_COND};
          default: d = '{len: 2'h2, clk: 4'h2, cls: pcit_pkg::CLS_PLAIN};
        endcase
      end
      // Low nibbles 6 and 7: pointer-indirect RAM forms. Most take two clocks
      // for one byte because the pointer is read before the operand; the
      // immediate and direct moves into RAM are two bytes, and the compare
      // through the pointer is the only four/five clock branch.
      4'h6, 4'h7: begin
        case (op[7:4])
          4'h7, 4'h8, 4'ha: d = '{len: 2'h2, clk: 4'h2, cls: pcit_pkg::CLS_PLAIN};
          4'hb: d = '{len: 2'h3, clk: 4'h4, cls: pcit_pkg::CLS_COND};
          default: d = '{len: 2'h1, clk: 4'h2, cls: pcit_pkg::CLS_PLAIN};
        endcase
      end
      // Low nibbles 8 to f: working register forms. Arithmetic and
      // increment run in one clock; moves with a byte operand take two,
      // compare-immediate takes three, decrement-and-branch two.
      // One shared record per row keeps the table small.
      default: begin
        case (op[7:4])
          4'h7, 4'h8, 4'ha: d = '{len: 2'h2, clk: 4'h2, cls: pcit_pkg::CLS_PLAIN};
          4'hb: d = '{len: 2'h3, clk: 4'h3, cls: pcit_pkg::CLS_COND};
          4'hd: d = '{len: 2'h2, clk: 4'h2, cls: pcit_pkg::CLS_COND};
          default: d = '{len: 2'h1, clk: 4'h1, cls: pcit_pkg::CLS_PLAIN};
        endcase
      end
    endcase
    return d;
  endfunction

  // ==========================================================================
  // Sequencer state
  // Three states are enough: fetch overlaps the previous instruction's end,
  // execute counts the remaining clocks, discard burns the one clock a taken
  // conditional branch needs. A limitation: the code store must answer in the
  // same cycle; a registered store would need an extra wait state here.
  // The clock index is cleared whenever the sequencer sits in fetch so that
  // downstream logic never mistakes a one-clock instruction for a longer one.
  // Decode records are held for the whole instruction so the strobes never
  // see the next opcode's class before retirement.
  pcit_pkg::pcit_state_e state_q;
  pcit_pkg::pcit_dec_s dec_q;
  pcit_pkg::pcit_dec_s dec_now;
  logic [15:0] pc_q;
  logic [3:0] cyc_q;
  logic [7:0] opcode_q;
  logic [7:0] opnd1_q;
  logic [7:0] opnd2_q;
  logic done_q;
  logic last_exec;
  logic take_byte;

  // Decode straight off the code store in the fetch clock
  assign dec_now = decode(CODE_DATA);

  // Final clock of a multi-clock instruction, counted in system clocks only
  assign last_exec = (state_q == pcit_pkg::ST_EXEC) && (cyc_q == dec_q.clk - 4'h1);

  // Operand bytes are consumed only while the index is inside the length
  assign take_byte = (state_q == pcit_pkg::ST_EXEC) && (cyc_q < {2'h0, dec_q.len});

  // State transitions
  // One-clock instructions stay in fetch, so back-to-back single clocks run
  // at one per cycle. The branch condition is only looked at in the last
  // execute clock; the datapath must have it settled by then.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= pcit_pkg::ST_FETCH;
    end else begin
      case (state_q)
        pcit_pkg::ST_FETCH: begin
          if (dec_now.clk != 4'h1) begin
            state_q <= pcit_pkg::ST_EXEC;
          end
        end
        pcit_pkg::ST_EXEC: begin
          if (last_exec) begin
            if (dec_q.cls == pcit_pkg::CLS_COND && BR_COND) begin
              state_q <= pcit_pkg::ST_DISCARD;
            end else begin
              state_q <= pcit_pkg::ST_FETCH;
            end
          end
        end
        pcit_pkg::ST_DISCARD: state_q <= pcit_pkg::ST_FETCH;
        default: state_q <= pcit_pkg::ST_FETCH;
      endcase
    end
  end

  // Clock index within the instruction; fetch clock is index zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cyc_q <= 4'h0;
    end else if (state_q == pcit_pkg::ST_FETCH) begin
      // Only a multi-clock instruction leaves fetch; a one-clock one keeps index zero
      cyc_q <= (dec_now.clk != 4'h1) ? 4'h1 : 4'h0;
    end else if (state_q == pcit_pkg::ST_EXEC && !last_exec) begin
      cyc_q <= cyc_q + 4'h1;
    end else begin
      cyc_q <= 4'h0;
    end
  end

  // Program counter; on a taken branch the prefetched byte is dropped and the
  // target is loaded in the spare clock, so no stale opcode enters decode
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pc_q <= pcit_pkg::RESET_PC;
    end else if (state_q == pcit_pkg::ST_DISCARD) begin
      pc_q <= BR_TARGET;
    end else if (last_exec && dec_q.cls == pcit_pkg::CLS_JUMP) begin
      pc_q <= BR_TARGET;
    end else if (state_q == pcit_pkg::ST_FETCH || take_byte) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  // Instruction record and operand capture
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      opcode_q <= pcit_pkg::NOP_OPCODE;
      dec_q <= '{len: 2'h1, clk: 4'h1, cls: pcit_pkg::CLS_PLAIN};
      opnd1_q <= 8'h00;
      opnd2_q <= 8'h00;
    end else if (state_q == pcit_pkg::ST_FETCH) begin
      opcode_q <= CODE_DATA;
      dec_q <= dec_now;
    end else if (take_byte) begin
      if (cyc_q == 4'h1) begin
        opnd1_q <= CODE_DATA;
      end else begin
        opnd2_q <= CODE_DATA;
      end
    end
  end

  // Retire pulse, one clock after the last clock of any instruction
  // Registered so it never glitches with the branch condition; a taken
  // branch retires from the discard clock instead of its last execute clock.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == pcit_pkg::ST_FETCH && dec_now.clk == 4'h1)
             || (last_exec && !(dec_q.cls == pcit_pkg::CLS_COND && BR_COND))
             || (state_q == pcit_pkg::ST_DISCARD);
    end
  end

  // ==========================================================================
  // Outputs
  // Memory strobes fire in the last clock so the datapath has settled the
  // address; there is no off-chip bus, only these on-chip targets
  assign ONCHIP_EXTERNAL_RAM_SPACE_RD = last_exec && dec_q.cls == pcit_pkg::CLS_XRD;
  assign ONCHIP_EXTERNAL_RAM_SPACE_WR = last_exec && dec_q.cls == pcit_pkg::CLS_XWR && !PROG_STORE_WE;
  assign FLASH_WR = last_exec && dec_q.cls == pcit_pkg::CLS_XWR && PROG_STORE_WE;
  assign FLASH_RD = last_exec && dec_q.cls == pcit_pkg::CLS_CODERD;
  assign MULDIV_STEP = (state_q == pcit_pkg::ST_EXEC)
                    && (dec_q.cls == pcit_pkg::CLS_MUL || dec_q.cls == pcit_pkg::CLS_DIV);
  assign EXEC_LAST = last_exec;
  assign CODE_ADDR = pc_q;
  assign OPCODE = opcode_q;
  assign OPERAND1 = opnd1_q;
  assign OPERAND2 = opnd2_q;
  assign EXEC_CLASS = dec_q.cls;
  assign EXEC_CYCLE = cyc_q;
  assign INSTR_DONE = done_q;

endmodule

// File: test/pcit_code_store.sv
// Behavioural on-chip program store answering a fetch in the same cycle.
// Assumes the bench preloads mem; unloaded bytes read as the no-operation code.
module pcit_code_store (
  input wire logic [15:0] CODE_ADDR, // Fetch address from the core
  output logic [7:0] CODE_DATA // Byte at that address
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:255];
  // Clear the store so stray fetches decode as no-operation
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  // Only the low byte decodes; programs here stay within 256 bytes
  assign CODE_DATA = mem[CODE_ADDR[7:0]];
endmodule

// File: test/pcit_exec_checker.sv
// Concurrent checks on the execution sequencer's ports.
// Assumes one clock domain and the active-high asynchronous reset.
module pcit_exec_checker (
  input wire logic CLK, // System clock
  input wire logic RST, // Reset, active high
  input wire logic [15:0] CODE_ADDR, // Fetch address
  input wire logic BR_COND, // Branch condition
  input wire logic [15:0] BR_TARGET, // Branch destination
  input wire logic PROG_STORE_WE, // Program store write enable
  input wire pcit_pkg::pcit_cls_e EXEC_CLASS, // Current class
  input wire logic [3:0] EXEC_CYCLE, // Clock index
  input wire logic EXEC_LAST, // Final clock
  input wire logic MULDIV_STEP, // Multiply/divide step
  input wire logic ONCHIP_EXTERNAL_RAM_SPACE_WR, // RAM write strobe
  input wire logic FLASH_WR, // Flash write strobe
  input wire logic INSTR_DONE // Retire pulse
);
  // ==========================================================================
  // Timing and steering properties
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  max_clocks_a: assert property (EXEC_CYCLE < pcit_pkg::MAX_CLOCKS) else $error("exec cycle too long");
  mul_span_a: assert property (EXEC_CLASS == pcit_pkg::CLS_MUL && EXEC_CYCLE == 4'h1 |->
    ##2 (EXEC_LAST && EXEC_CYCLE == 4'h3)) else $error("multiply span wrong");
  div_span_a: assert property (EXEC_CLASS == pcit_pkg::CLS_DIV && EXEC_CYCLE == 4'h1 |->
    !EXEC_LAST [*6] ##1 (EXEC_LAST && EXEC_CYCLE == 4'h7)) else $error("divide span wrong");
  step_gate_a: assert property (MULDIV_STEP |-> EXEC_CYCLE != 4'h0 &&
    (EXEC_CLASS == pcit_pkg::CLS_MUL || EXEC_CLASS == pcit_pkg::CLS_DIV)) else $error("stray step");
  onchip_external_ram_space_steer_a: assert property (ONCHIP_EXTERNAL_RAM_SPACE_WR |-> !PROG_STORE_WE && EXEC_LAST &&
    EXEC_CLASS == pcit_pkg::CLS_XWR) else $error("ram write misplaced");
  flash_steer_a: assert property (FLASH_WR |-> PROG_STORE_WE && EXEC_LAST &&
    EXEC_CLASS == pcit_pkg::CLS_XWR) else $error("flash write misplaced");
  write_once_a: assert property (EXEC_LAST && EXEC_CLASS == pcit_pkg::CLS_XWR |->
    ONCHIP_EXTERNAL_RAM_SPACE_WR != FLASH_WR) else $error("write target not unique");
  done_next_a: assert property (EXEC_LAST && !(EXEC_CLASS == pcit_pkg::CLS_COND && BR_COND) |=>
    INSTR_DONE) else $error("retire late");
  taken_skip_a: assert property (EXEC_LAST && EXEC_CLASS == pcit_pkg::CLS_COND && BR_COND |=>
    !INSTR_DONE ##1 (INSTR_DONE && CODE_ADDR == $past(BR_TARGET))) else $error("taken branch wrong");
  reset_fetch_a: assert property ($past(RST) |-> CODE_ADDR == 16'h0000) else $error("fetch not at zero");
  retire_idle_a: assert property (INSTR_DONE |-> EXEC_CYCLE == 4'h0) else $error("retire with index set");
  cover property (EXEC_CLASS == pcit_pkg::CLS_MUL && EXEC_LAST);
  cover property (EXEC_CLASS == pcit_pkg::CLS_DIV && EXEC_LAST);
  cover property (FLASH_WR);
  cover property (EXEC_LAST && EXEC_CLASS == pcit_pkg::CLS_COND && BR_COND);
endmodule

bind pcit_exec_ctrl pcit_exec_checker u_chk (.CLK(CLK), .RST(RST), .CODE_ADDR(CODE_ADDR),
  .BR_COND(BR_COND), .BR_TARGET(BR_TARGET), .PROG_STORE_WE(PROG_STORE_WE), .EXEC_CLASS(EXEC_CLASS),
  .EXEC_CYCLE(EXEC_CYCLE), .EXEC_LAST(EXEC_LAST), .MULDIV_STEP(MULDIV_STEP), .ONCHIP_EXTERNAL_RAM_SPACE_WR(ONCHIP_EXTERNAL_RAM_SPACE_WR),
  .FLASH_WR(FLASH_WR), .INSTR_DONE(INSTR_DONE));

// File: test/tb_top.sv
// Self-checking bench: runs each opcode twice back to back, times the gap.
// Assumes the store model answers fetches combinationally; branch target 0.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, br_cond = 1'b0, we = 1'b0, done, xrd, xwr, fwr, frd;
  logic [15:0] br_target = 16'h0000, code_addr;
  logic [7:0] code_data, opcode, opnd1, opnd2;
  int error_cnt = 0, n_compared = 0, c_xrd, c_xwr, c_fwr, c_frd;
  pcit_exec_ctrl uut (.CLK(clk), .RST(rst), .CODE_ADDR(code_addr), .CODE_DATA(code_data),
    .BR_COND(br_cond), .BR_TARGET(br_target), .PROG_STORE_WE(we), .OPCODE(opcode), .OPERAND1(opnd1),
    .OPERAND2(opnd2), .EXEC_CLASS(), .EXEC_CYCLE(), .EXEC_LAST(), .MULDIV_STEP(), .ONCHIP_EXTERNAL_RAM_SPACE_RD(xrd),
    .ONCHIP_EXTERNAL_RAM_SPACE_WR(xwr), .FLASH_WR(fwr), .FLASH_RD(frd), .INSTR_DONE(done));
  pcit_code_store code_store (.CODE_ADDR(code_addr), .CODE_DATA(code_data));
  // ==========================================================================
  // Clock, checks and closing
  initial forever #5 clk = ~clk;
  task automatic chk_addr(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin error_cnt++; $display("ERROR %s expected %h seen %h", nm, exp, got); end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin error_cnt++; $display("ERROR %s expected %h seen %h", nm, exp, got); end
  endtask
  task automatic chk_cnt(input string nm, input int exp, input int got);
    n_compared++;
    if (got != exp) begin error_cnt++; $display("ERROR %s expected %0d seen %0d", nm, exp, got); end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Repeating copies of op; gap between the first two retire pulses is the second one's clocks
  task automatic run_instr(input logic [7:0] op, input int len, clks, input logic cond, input logic [15:0] nxt);
    int n;
    rst = 1'b1;
    br_cond = cond;
    for (int i = 0; i < 16; i++) code_store.mem[i] = (i % len == 0) ? op : ((i % len == 1) ? 8'h01 : 8'h02);
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin @(posedge clk); #1 n++; end
    chk_addr("next fetch", nxt, code_addr);
    chk_byte("opcode", op, opcode);
    chk_byte("operand one", (len > 1) ? 8'h01 : 8'h00, opnd1);
    chk_byte("operand two", (len > 2) ? 8'h02 : 8'h00, opnd2);
    {n, c_xrd, c_xwr, c_fwr, c_frd} = '0;
    do begin
      @(posedge clk);
      #1 n++;
      c_xrd += int'(xrd === 1'b1); c_xwr += int'(xwr === 1'b1);
      c_fwr += int'(fwr === 1'b1); c_frd += int'(frd === 1'b1);
    end while (done !== 1'b1 && n < 20);
    chk_cnt("clocks", clks, n);
  endtask
  // Register, indirect, direct and immediate forms plus long ones
  task automatic t_timing;
    run_instr(8'h28, 1, 1, 1'b0, 16'h0001);
    run_instr(8'h38, 1, 1, 1'b0, 16'h0001);
    run_instr(8'h08, 1, 1, 1'b0, 16'h0001);
    run_instr(8'h18, 1, 1, 1'b0, 16'h0001);
    run_instr(8'h26, 1, 2, 1'b0, 16'h0001);
    run_instr(8'h96, 1, 2, 1'b0, 16'h0001);
    run_instr(8'h16, 1, 2, 1'b0, 16'h0001);
    run_instr(8'h25, 2, 2, 1'b0, 16'h0002);
    run_instr(8'h05, 2, 2, 1'b0, 16'h0002);
    run_instr(8'h15, 2, 2, 1'b0, 16'h0002);
    run_instr(8'h24, 2, 2, 1'b0, 16'h0002);
    run_instr(8'h94, 2, 2, 1'b0, 16'h0002);
    run_instr(8'h54, 2, 2, 1'b0, 16'h0002);
    run_instr(8'ha3, 1, 1, 1'b0, 16'h0001);
    run_instr(8'h53, 3, 3, 1'b0, 16'h0003);
    run_instr(8'h52, 2, 2, 1'b0, 16'h0002);
    run_instr(8'ha4, 1, 4, 1'b0, 16'h0001);
    run_instr(8'h84, 1, 8, 1'b0, 16'h0001);
    run_instr(8'ha5, 1, 1, 1'b0, 16'h0001);
    run_instr(8'h02, 3, 4, 1'b0, 16'h0000);
  endtask
  // Not taken versus taken, which loops back to address zero
  task automatic t_branch;
    run_instr(8'h40, 2, 2, 1'b0, 16'h0002);
    run_instr(8'h40, 2, 3, 1'b1, 16'h0000);
    run_instr(8'h20, 3, 3, 1'b0, 16'h0003);
    run_instr(8'h20, 3, 4, 1'b1, 16'h0000);
    run_instr(8'hb6, 3, 4, 1'b0, 16'h0003);
    run_instr(8'hb6, 3, 5, 1'b1, 16'h0000);
    run_instr(8'hd8, 2, 3, 1'b1, 16'h0000);
  endtask
  // Write steering by the enable bit, and both read paths
  task automatic t_external_data_move;
    run_instr(8'hf0, 1, 3, 1'b0, 16'h0001);
    chk_cnt("ram writes", 1, c_xwr);
    chk_cnt("flash writes", 0, c_fwr);
    we = 1'b1;
    run_instr(8'hf0, 1, 3, 1'b0, 16'h0001);
    chk_cnt("ram writes", 0, c_xwr);
    chk_cnt("flash writes", 1, c_fwr);
    we = 1'b0;
    run_instr(8'he0, 1, 3, 1'b0, 16'h0001);
    chk_cnt("ram reads", 1, c_xrd);
    run_instr(8'h93, 1, 3, 1'b0, 16'h0001);
    chk_cnt("flash reads", 1, c_frd);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 chk_addr("reset fetch", 16'h0000, code_addr);
    t_timing();
    t_branch();
    t_external_data_move();
    conclude();
  end
  // Watchdog well beyond the few hundred cycles needed
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule
